// file: rtl/timer_count_start_sync.sv
// timer core: six up-counters, general compare/capture registers, start and sync control
// assumes: strobes one cycle long, never together; tick and pin inputs synchronous to CLOCK
//
// Function
// - six 16-bit counters, each readable and writable by software
// - reset and hardware standby force every counter to zero
// - counters are accessed as whole 16-bit words only
// - sixteen general registers: four on channels 0 and 3, two elsewhere
// - channels 0 and 3 pair first with third, second with fourth as buffers
// - general registers are accessed as whole 16-bit words only
// - start bits 5..0 run or halt the matching counter
// - halting keeps the pin at its current compare output level
// - writing pin control of a halted channel drives its initial level
// - channels 0 to 2 have no timer pins
// - bits 7 and 6 of start and sync registers read zero
// - sync bits 5..0 place the matching counter in synchronous operation
// - synchronous counters preset together; those whose clear source is CLR_SYNC also clear together
// - a channel with sync bit zero presets and clears on its own
// - wrap from maximum to zero sets overflow flag and keeps counting
// - periodic match sets the match flag and clears the counter
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ns

module timer_count_start_sync
  import timer_pkg::*;
#(
  parameter int NCH = timer_pkg::NUM_CH
) (
  // clock and reset
  input  wire logic                  CLOCK,
  input  wire logic                  RESET_N,
  input  wire logic                  STANDBY,
  // register port
  input  wire timer_pkg::bus_req_t   REQ,
  output logic [15:0]                RDATA,
  // count clock edges, one per channel
  input  wire logic [5:0]            COUNT_TICK,
  // timer pins of channels 3 to 5
  input  wire logic [2:0]            PIN_IN,
  output logic [2:0]                 PIN_OUT,
  output logic [2:0]                 PIN_OE
);
  import timer_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic gen_present(input int ch, input int idx);
    gen_present = (idx < 2) || BUF_CH_MASK[ch];
  endfunction : gen_present

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int ofs);
    hit = (a == 8'(base + 8'(ofs)));
  endfunction : hit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] cnt_q   [NUM_CH];
  logic [15:0] gen_q   [NUM_CH][GEN_PER_CH];
  logic [7:0]  ctrl_q  [NUM_CH];
  logic [5:0]  start_q;
  logic [5:0]  sync_q;
  logic [5:0]  ovf_q;
  logic [5:0]  mfa_q;
  logic [5:0]  mfb_q;
  logic [2:0]  pin_q;
  logic [2:0]  pin_in_q;
  logic [15:0] rdata_q;

  // ----------------------------------------------------------------
  // per-channel events
  // ----------------------------------------------------------------
  logic [5:0]  adv;
  logic [5:0]  cmp_a;
  logic [5:0]  cmp_b;
  logic [5:0]  cap;
  logic [5:0]  own_clr;
  logic [5:0]  clr;
  logic [5:0]  cnt_wr;
  logic [5:0]  preset;
  logic [5:0]  ctrl_wr;
  logic [5:0]  stat_wr;
  logic [5:0]  buf_en;
  logic        sync_clr_any;
  logic        sync_wr_any;
  logic [5:0]  pin_rise;

  assign pin_rise = {PIN_IN & ~pin_in_q, 3'h0};

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      adv[i]     = start_q[i] & COUNT_TICK[i];
      buf_en[i]  = ctrl_q[i][CTRL_BUF] & BUF_CH_MASK[i];
      cmp_a[i]   = adv[i] & ~ctrl_q[i][CTRL_CAPTURE] & (cnt_q[i] == gen_q[i][0]);
      cmp_b[i]   = adv[i] & (cnt_q[i] == gen_q[i][1]);
      cap[i]     = ctrl_q[i][CTRL_CAPTURE] & ~ctrl_q[i][CTRL_PIN_OUT]
                 & pin_rise[i] & PIN_CH_MASK[i];
      own_clr[i] = ((clear_src_t'(ctrl_q[i][CTRL_CLR_LSB +: 2]) == CLR_FIRST) & cmp_a[i])
                 | ((clear_src_t'(ctrl_q[i][CTRL_CLR_LSB +: 2]) == CLR_SECOND) & cmp_b[i]);
      cnt_wr[i]  = REQ.wr & hit(REQ.addr, OFS_COUNTER, i);
      ctrl_wr[i] = REQ.wr & hit(REQ.addr, OFS_CTRL, i);
      stat_wr[i] = REQ.wr & hit(REQ.addr, OFS_STATUS, i);
    end
    sync_clr_any = |(own_clr & sync_q);
    sync_wr_any  = |(cnt_wr & sync_q);
    for (int i = 0; i < NUM_CH; i++) begin
      clr[i]    = own_clr[i] | (sync_q[i] & sync_clr_any
                & (clear_src_t'(ctrl_q[i][CTRL_CLR_LSB +: 2]) == CLR_SYNC));
      preset[i] = cnt_wr[i] | (sync_q[i] & sync_wr_any);
    end
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cnt_q[i] <= COUNTER_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (STANDBY) begin
          cnt_q[i] <= COUNTER_RESET;
        end else if (preset[i]) begin
          cnt_q[i] <= REQ.wdata;
        end else if (clr[i]) begin
          cnt_q[i] <= COUNTER_RESET;
        end else if (adv[i]) begin
          cnt_q[i] <= cnt_q[i] + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // general registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < NUM_CH; i++) begin
        for (int j = 0; j < GEN_PER_CH; j++) begin
          gen_q[i][j] <= GENERAL_RESET;
        end
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        for (int j = 0; j < GEN_PER_CH; j++) begin
          if (gen_present(i, j)) begin
            if (REQ.wr && hit(REQ.addr, OFS_GENERAL, i*GEN_PER_CH + j)) begin
              gen_q[i][j] <= REQ.wdata;
            end else if (j == 0 && cap[i]) begin
              gen_q[i][j] <= cnt_q[i];
            end else if (j == 2 && cap[i] && buf_en[i]) begin
              gen_q[i][j] <= gen_q[i][0];
            end else if (j == 0 && cmp_a[i] && buf_en[i]) begin
              gen_q[i][j] <= gen_q[i][2];
            end else if (j == 1 && cmp_b[i] && buf_en[i]) begin
              gen_q[i][j] <= gen_q[i][3];
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // start, sync and channel control
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      start_q <= START_RESET;
      sync_q  <= SYNC_RESET;
    end else begin
      if (REQ.wr && REQ.addr == OFS_START) begin
        start_q <= REQ.wdata[5:0];
      end
      if (REQ.wr && REQ.addr == OFS_SYNC) begin
        sync_q <= REQ.wdata[5:0];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ctrl_q[i] <= CTRL_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ctrl_wr[i]) begin
          ctrl_q[i] <= REQ.wdata[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags, set wins over clear-by-zero
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ovf_q <= 6'h00;
      mfa_q <= 6'h00;
      mfb_q <= 6'h00;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        ovf_q[i] <= (adv[i] & (cnt_q[i] == COUNTER_MAX) & ~clr[i] & ~preset[i] & ~STANDBY)
                  | (ovf_q[i] & ~(stat_wr[i] & ~REQ.wdata[STAT_OVERFLOW]));
        mfa_q[i] <= cmp_a[i] | cap[i]
                  | (mfa_q[i] & ~(stat_wr[i] & ~REQ.wdata[STAT_MATCH_A]));
        mfb_q[i] <= cmp_b[i]
                  | (mfb_q[i] & ~(stat_wr[i] & ~REQ.wdata[STAT_MATCH_B]));
      end
    end
  end

  // ----------------------------------------------------------------
  // timer pins of channels 3 to 5
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_q    <= 3'h0;
      pin_in_q <= 3'h0;
    end else begin
      pin_in_q <= PIN_IN;
      for (int k = 0; k < NUM_PINS; k++) begin
        if (ctrl_wr[k+PIN_CH_FIRST] && !start_q[k+PIN_CH_FIRST]) begin
          pin_q[k] <= REQ.wdata[CTRL_PIN_INIT];
        end else if (cmp_a[k+PIN_CH_FIRST] && ctrl_q[k+PIN_CH_FIRST][CTRL_PIN_OUT]) begin
          unique case (pin_act_t'(ctrl_q[k+PIN_CH_FIRST][CTRL_ACT_LSB +: 2]))
            ACT_NONE:   pin_q[k] <= pin_q[k];
            ACT_LOW:    pin_q[k] <= 1'b0;
            ACT_HIGH:   pin_q[k] <= 1'b1;
            ACT_TOGGLE: pin_q[k] <= ~pin_q[k];
          endcase
        end
      end
    end
  end

  always_comb begin
    for (int k = 0; k < NUM_PINS; k++) begin
      PIN_OE[k] = ctrl_q[k+PIN_CH_FIRST][CTRL_PIN_OUT];
    end
  end
  assign PIN_OUT = pin_q;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= 16'h0000;
      if (REQ.rd) begin
        if (REQ.addr == OFS_START) begin
          rdata_q <= {10'h000, start_q};
        end
        if (REQ.addr == OFS_SYNC) begin
          rdata_q <= {10'h000, sync_q};
        end
        for (int i = 0; i < NUM_CH; i++) begin
          if (hit(REQ.addr, OFS_COUNTER, i)) begin
            rdata_q <= cnt_q[i];
          end
          if (hit(REQ.addr, OFS_CTRL, i)) begin
            rdata_q <= {8'h00, ctrl_q[i]};
          end
          if (hit(REQ.addr, OFS_STATUS, i)) begin
            rdata_q <= {11'h000, ovf_q[i], 2'h0, mfb_q[i], mfa_q[i]};
          end
          for (int j = 0; j < GEN_PER_CH; j++) begin
            if (gen_present(i, j) && hit(REQ.addr, OFS_GENERAL, i*GEN_PER_CH + j)) begin
              rdata_q <= gen_q[i][j];
            end
          end
        end
      end
    end
  end
  assign RDATA = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
    a_standby_zero: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      STANDBY |=> cnt_q[g] == COUNTER_RESET)
      else $error("counter not zero in standby");
    a_halt_holds: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (!start_q[g] && !preset[g] && !clr[g] && !STANDBY) [*2] |-> $stable(cnt_q[g]))
      else $error("halted counter moved");
    a_count_step: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (adv[g] && !preset[g] && !clr[g] && !STANDBY) |=> cnt_q[g] == 16'($past(cnt_q[g]) + 16'h0001))
      else $error("counter did not step by one");
    a_wrap_flag: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (adv[g] && cnt_q[g] == COUNTER_MAX && !preset[g] && !clr[g] && !STANDBY)
      |=> (cnt_q[g] == COUNTER_RESET) && ovf_q[g])
      else $error("wrap did not set overflow");
    a_period_clear: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (cmp_a[g] && ctrl_q[g][1:0] == CLR_FIRST && !preset[g] && !STANDBY)
      |=> (cnt_q[g] == COUNTER_RESET) && mfa_q[g])
      else $error("period match did not clear");
    a_sync_preset: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (sync_q[g] && sync_wr_any && !STANDBY) |=> cnt_q[g] == $past(REQ.wdata))
      else $error("synchronous preset missed");
    a_sync_clear: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (sync_q[g] && sync_clr_any && ctrl_q[g][1:0] == CLR_SYNC && !preset[g] && !STANDBY)
      |=> cnt_q[g] == COUNTER_RESET)
      else $error("synchronous clear missed");
    a_indep_preset: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (!sync_q[g] && |cnt_wr && !cnt_wr[g] && !adv[g] && !STANDBY) |=> $stable(cnt_q[g]))
      else $error("independent counter was preset");
  end

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin_chk
    a_pin_retain: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (!start_q[p+PIN_CH_FIRST] && !ctrl_wr[p+PIN_CH_FIRST]) |=> $stable(PIN_OUT[p]))
      else $error("pin changed while halted");
    a_pin_initial: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (ctrl_wr[p+PIN_CH_FIRST] && !start_q[p+PIN_CH_FIRST])
      |=> PIN_OUT[p] == $past(REQ.wdata[CTRL_PIN_INIT]))
      else $error("pin not at initial level");
    a_capture_load: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (cap[p+PIN_CH_FIRST] && !(REQ.wr && hit(REQ.addr, OFS_GENERAL, (p + PIN_CH_FIRST) * GEN_PER_CH)))
      |=> gen_q[p+PIN_CH_FIRST][0] == $past(cnt_q[p+PIN_CH_FIRST]))
      else $error("capture did not load counter");
  end

  a_buffer_load: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (buf_en[0] && cmp_a[0] && !(REQ.wr && REQ.addr == OFS_GENERAL))
    |=> gen_q[0][0] == $past(gen_q[0][2]))
    else $error("buffer not transferred");
  a_reserved_read: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (REQ.rd && (REQ.addr == OFS_START || REQ.addr == OFS_SYNC)) |=> RDATA[7:6] == 2'h0)
    else $error("reserved bits not zero");

endmodule : timer_count_start_sync

// file: rtl/timer_pkg.sv
// package: register map, field layout, reset values and bus carrier of the timer core
// assumes: one 16-bit word per register index on the plain register port
package timer_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int          NUM_CH        = 6;
  localparam int          CNT_W         = 16;
  localparam int          GEN_PER_CH    = 4;
  localparam int          PIN_CH_FIRST  = 3;
  localparam int          NUM_PINS      = 3;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_COUNTER   = 8'h00;
  localparam logic [7:0]  OFS_GENERAL   = 8'h10;
  localparam logic [7:0]  OFS_START     = 8'h30;
  localparam logic [7:0]  OFS_SYNC      = 8'h31;
  localparam logic [7:0]  OFS_CTRL      = 8'h38;
  localparam logic [7:0]  OFS_STATUS    = 8'h40;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] COUNTER_MAX   = 16'hFFFF;
  localparam logic [15:0] GENERAL_RESET = 16'hFFFF;
  localparam logic [5:0]  START_RESET   = 6'h00;
  localparam logic [5:0]  SYNC_RESET    = 6'h00;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [5:0]  BUF_CH_MASK   = 6'h09;
  localparam logic [5:0]  PIN_CH_MASK   = 6'h38;

  // ----------------------------------------------------------------
  // channel control fields
  // ----------------------------------------------------------------
  localparam int          CTRL_CLR_LSB  = 0;
  localparam int          CTRL_BUF      = 2;
  localparam int          CTRL_PIN_OUT  = 3;
  localparam int          CTRL_PIN_INIT = 4;
  localparam int          CTRL_CAPTURE  = 5;
  localparam int          CTRL_ACT_LSB  = 6;

  // ----------------------------------------------------------------
  // channel status fields
  // ----------------------------------------------------------------
  localparam int          STAT_MATCH_A  = 0;
  localparam int          STAT_MATCH_B  = 1;
  localparam int          STAT_OVERFLOW = 4;

  typedef enum logic [1:0] {
    CLR_NONE   = 2'h0,
    CLR_FIRST  = 2'h1,
    CLR_SECOND = 2'h2,
    CLR_SYNC   = 2'h3
  } clear_src_t;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_LOW    = 2'h1,
    ACT_HIGH   = 2'h2,
    ACT_TOGGLE = 2'h3
  } pin_act_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } bus_req_t;

endpackage : timer_pkg

// file: tb/tb.sv
// testbench: directed scenarios for the timer core through its register port, ticks and pins
// assumes: design package compiled first; clock 50 ns; registers read one cycle after the read strobe
`timescale 1ns/1ns

module tb;
  import timer_pkg::*;

  logic        clock;
  logic        reset_n;
  logic        standby;
  bus_req_t    req;
  logic [15:0] rdata;
  logic [5:0]  tick_q;
  logic [2:0]  pin_in;
  logic [2:0]  pin_out;
  logic [2:0]  pin_oe;
  int          mismatches;
  int          comparisons;
  logic [15:0] v;

  timer_count_start_sync u_timer_count_start_sync (
    .CLOCK      (clock),
    .RESET_N    (reset_n),
    .STANDBY    (standby),
    .REQ        (req),
    .RDATA      (rdata),
    .COUNT_TICK (tick_q),
    .PIN_IN     (pin_in),
    .PIN_OUT    (pin_out),
    .PIN_OE     (pin_oe)
  );

  // ----------------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    #(50 * 3000);
    mismatches++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // bus, tick and compare tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clock);
    req.wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clock);
    req.rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic tick(input logic [5:0] m, input int n);
    repeat (n) begin
      @(posedge clock);
      tick_q <= m;
      @(posedge clock);
      tick_q <= 6'h00;
    end
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
    rd(a, v);
    chk(v, exp, "register read");
  endtask : chk_reg

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 6; i++) chk_reg(OFS_COUNTER + 8'(i), 16'h0000);
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 4; j++) begin
        chk_reg(OFS_GENERAL + 8'(4 * i + j), (j < 2 || i == 0 || i == 3) ? 16'hFFFF : 16'h0000);
      end
    end
    chk_reg(OFS_START, 16'h0000);
    chk_reg(OFS_SYNC, 16'h0000);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_access;
    for (int i = 0; i < 6; i++) wr(OFS_COUNTER + 8'(i), 16'hA5C0 + 16'(i));
    for (int i = 0; i < 6; i++) chk_reg(OFS_COUNTER + 8'(i), 16'hA5C0 + 16'(i));
    wr(OFS_GENERAL + 8'h0E, 16'h1234);
    chk_reg(OFS_GENERAL + 8'h0E, 16'h1234);
    wr(OFS_GENERAL + 8'h07, 16'h4321);
    chk_reg(OFS_GENERAL + 8'h07, 16'h0000);
    wr(OFS_START, 16'h00C0);
    chk_reg(OFS_START, 16'h0000);
    wr(8'hF0, 16'hBEEF);
    chk_reg(8'hF0, 16'h0000);
    $display("test register access done");
  endtask : t_access

  task automatic t_count;
    wr(OFS_COUNTER + 8'h05, 16'h0000);
    wr(OFS_COUNTER + 8'h04, 16'h0010);
    wr(OFS_START, 16'h0020);
    tick(6'h30, 3);
    chk_reg(OFS_COUNTER + 8'h05, 16'h0003);
    chk_reg(OFS_COUNTER + 8'h04, 16'h0010);
    wr(OFS_START, 16'h0000);
    tick(6'h20, 2);
    chk_reg(OFS_COUNTER + 8'h05, 16'h0003);
    $display("test counting done");
  endtask : t_count

  task automatic t_overflow;
    wr(OFS_COUNTER + 8'h02, 16'hFFFF);
    wr(OFS_START, 16'h0004);
    tick(6'h04, 1);
    chk_reg(OFS_COUNTER + 8'h02, 16'h0000);
    rd(OFS_STATUS + 8'h02, v);
    chk(v & 16'h0010, 16'h0010, "overflow flag");
    tick(6'h04, 2);
    chk_reg(OFS_COUNTER + 8'h02, 16'h0002);
    wr(OFS_STATUS + 8'h02, 16'h0000);
    rd(OFS_STATUS + 8'h02, v);
    chk(v & 16'h0010, 16'h0000, "overflow cleared");
    wr(OFS_START, 16'h0000);
    $display("test overflow done");
  endtask : t_overflow

  task automatic t_periodic;
    wr(OFS_COUNTER + 8'h01, 16'h0000);
    wr(OFS_GENERAL + 8'h04, 16'h0003);
    wr(OFS_CTRL + 8'h01, 16'h0001);
    wr(OFS_START, 16'h0002);
    tick(6'h02, 3);
    chk_reg(OFS_COUNTER + 8'h01, 16'h0003);
    tick(6'h02, 1);
    chk_reg(OFS_COUNTER + 8'h01, 16'h0000);
    rd(OFS_STATUS + 8'h01, v);
    chk(v & 16'h0001, 16'h0001, "match flag");
    wr(OFS_START, 16'h0000);
    wr(OFS_CTRL + 8'h01, 16'h0000);
    $display("test periodic done");
  endtask : t_periodic

  task automatic t_buffer;
    wr(OFS_COUNTER, 16'h0000);
    wr(OFS_GENERAL, 16'h0002);
    wr(OFS_GENERAL + 8'h02, 16'h0055);
    wr(OFS_CTRL, 16'h0005);
    wr(OFS_START, 16'h0001);
    tick(6'h01, 3);
    chk_reg(OFS_GENERAL, 16'h0055);
    chk_reg(OFS_COUNTER, 16'h0000);
    wr(OFS_START, 16'h0000);
    wr(OFS_CTRL, 16'h0000);
    $display("test buffer done");
  endtask : t_buffer

  task automatic t_sync;
    wr(OFS_COUNTER, 16'h0111);
    wr(OFS_COUNTER + 8'h02, 16'h0222);
    wr(OFS_SYNC, 16'h00C6);
    chk_reg(OFS_SYNC, 16'h0006);
    wr(OFS_COUNTER + 8'h01, 16'h1234);
    chk_reg(OFS_COUNTER + 8'h02, 16'h1234);
    chk_reg(OFS_COUNTER, 16'h0111);
    wr(OFS_COUNTER, 16'h0999);
    chk_reg(OFS_COUNTER + 8'h01, 16'h1234);
    wr(OFS_SYNC, 16'h0000);
    $display("test synchronous preset done");
  endtask : t_sync

  task automatic t_pins;
    wr(OFS_CTRL + 8'h03, 16'h0018);
    #1;
    chk({14'h0, pin_oe[0], pin_out[0]}, 16'h0003, "initial level high");
    wr(OFS_CTRL + 8'h03, 16'h0008);
    #1;
    chk({14'h0, pin_oe[0], pin_out[0]}, 16'h0002, "initial level low");
    wr(OFS_COUNTER + 8'h03, 16'h0000);
    wr(OFS_GENERAL + 8'h0C, 16'h0001);
    wr(OFS_CTRL + 8'h03, 16'h0088);
    wr(OFS_START, 16'h0008);
    tick(6'h08, 2);
    #1;
    chk({15'h0, pin_out[0]}, 16'h0001, "compare output");
    wr(OFS_START, 16'h0000);
    repeat (3) @(posedge clock);
    #1;
    chk({15'h0, pin_out[0]}, 16'h0001, "retained output");
    wr(OFS_CTRL + 8'h03, 16'h00D8);
    wr(OFS_COUNTER + 8'h03, 16'h0000);
    wr(OFS_START, 16'h0008);
    tick(6'h08, 2);
    #1;
    chk({15'h0, pin_out[0]}, 16'h0000, "toggled output");
    wr(OFS_START, 16'h0000);
    wr(OFS_CTRL + 8'h03, 16'h0000);
    $display("test pins done");
  endtask : t_pins

  task automatic t_sync_clear;
    wr(OFS_COUNTER + 8'h01, 16'h0000);
    wr(OFS_COUNTER + 8'h02, 16'h0000);
    wr(OFS_GENERAL + 8'h04, 16'h0002);
    wr(OFS_CTRL + 8'h01, 16'h0001);
    wr(OFS_CTRL + 8'h02, 16'h0003);
    wr(OFS_SYNC, 16'h0006);
    wr(OFS_START, 16'h0006);
    tick(6'h06, 2);
    chk_reg(OFS_COUNTER + 8'h02, 16'h0002);
    tick(6'h06, 1);
    chk_reg(OFS_COUNTER + 8'h01, 16'h0000);
    chk_reg(OFS_COUNTER + 8'h02, 16'h0000);
    wr(OFS_START, 16'h0000);
    wr(OFS_SYNC, 16'h0000);
    wr(OFS_CTRL + 8'h01, 16'h0000);
    wr(OFS_CTRL + 8'h02, 16'h0000);
    $display("test synchronous clear done");
  endtask : t_sync_clear

  task automatic t_capture;
    wr(OFS_COUNTER + 8'h04, 16'h0000);
    wr(OFS_CTRL + 8'h04, 16'h0020);
    wr(OFS_START, 16'h0010);
    tick(6'h10, 5);
    @(posedge clock);
    pin_in <= 3'h2;
    chk_reg(OFS_GENERAL + 8'h10, 16'h0005);
    rd(OFS_STATUS + 8'h04, v);
    chk(v & 16'h0001, 16'h0001, "capture flag");
    chk({15'h0, pin_oe[1]}, 16'h0000, "capture pin not driven");
    pin_in <= 3'h0;
    wr(OFS_START, 16'h0000);
    wr(OFS_CTRL + 8'h04, 16'h0000);
    $display("test capture done");
  endtask : t_capture

  task automatic t_standby;
    wr(OFS_COUNTER + 8'h04, 16'h0077);
    @(posedge clock);
    standby <= 1'b1;
    @(posedge clock);
    standby <= 1'b0;
    chk_reg(OFS_COUNTER + 8'h04, 16'h0000);
    $display("test standby done");
  endtask : t_standby

  // ----------------------------------------------------------------
  // verdict
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    mismatches  = 0;
    comparisons = 0;
    reset_n     = 1'b0;
    standby     = 1'b0;
    req         = '0;
    tick_q      = 6'h00;
    pin_in      = 3'h0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_access();
    t_count();
    t_overflow();
    t_periodic();
    t_buffer();
    t_sync();
    t_pins();
    t_sync_clear();
    t_capture();
    t_standby();
    report_and_stop();
  end

endmodule : tb
